// ==== epwm_pkg.sv ====
// package: register map, field positions and types for the enhanced pwm unit
package epwm_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFF_COUNTER  = 8'h00;
   localparam logic [7:0] OFF_TCTRL    = 8'h04;
   localparam logic [7:0] OFF_LIMIT    = 8'h08;
   localparam logic [7:0] OFF_DUTY_LO  = 8'h0C;
   localparam logic [7:0] OFF_DUTY_HI  = 8'h10;
   localparam logic [7:0] OFF_UCTRL    = 8'h14;
   localparam logic [7:0] OFF_SHUT     = 8'h18;
   localparam logic [7:0] OFF_RESTART  = 8'h1C;
   localparam logic [7:0] OFF_FLAGS1   = 8'h20;
   localparam logic [7:0] OFF_FLAGS2   = 8'h24;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h28;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h2C;
   localparam logic [7:0] OFF_PWR      = 8'h30;
   localparam logic [7:0] OFF_DIR      = 8'h34;
   // reset values: unit registers clear, except limit and dir which reset to all ones
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [7:0] RST_LIMIT    = 8'hFF;
   localparam logic [7:0] RST_DIR      = 8'hFF;
   // field positions
   localparam int TCTRL_ON      = 2;
   localparam int UCTRL_DC_LSB  = 4;
   localparam int UCTRL_M_LSB   = 6;
   localparam int SHUT_ASE      = 7;
   localparam int SHUT_SRC_LSB  = 4;
   localparam int SHUT_AC_LSB   = 2;
   localparam int RESTART_EN    = 7;
   localparam int FLAGS1_PERIOD = 1;
   localparam int FLAGS2_OSCF   = 7;
   localparam int PWR_FSCM      = 2;
   // masks of implemented bits; the two REDUCED masks apply on the reduced-pin variant only
   localparam logic [7:0] SHUT_REDUCED_MASK    = 8'hFC;
   localparam logic [7:0] RESTART_REDUCED_MASK = 8'h80;
   localparam logic [7:0] TCTRL_MASK           = 8'h7F;
   localparam logic [7:0] FLAGS2_MASK          = 8'h80;
   localparam logic [7:0] IRQ_MASK             = 8'h03;
   // power mode encoding written by software
   localparam logic [1:0] PWR_RUN      = 2'h0;
   localparam logic [1:0] PWR_PRIMARY_CLOCK_IDLE_MODE = 2'h1;
   localparam logic [1:0] PWR_LP_IDLE  = 2'h2;
   localparam logic [1:0] PWR_SLEEP    = 2'h3;
   // bit positions in the event status register
   localparam int EV_PERIOD = 0;
   localparam int EV_OSCF   = 1;
   // clock source currently feeding the unit
   typedef enum logic [1:0] {
      src_primary,
      src_low_power,
      src_internal
   } clk_src_e;
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;
   // pwm pin group
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] oe;
   } pwm_pins_s;
endpackage : epwm_pkg

// ==== epwm_switch_model.sv ====
// model of the external switch drivers on the pwm pins
module epwm_switch_model (
   // pins from the unit
   input  wire epwm_pkg::pwm_pins_s pins,
   // gate levels seen by the switch stages
   output logic [3:0]              gate
);
   timeunit 1ns;
   timeprecision 1ps;
   // undriven pins fall to the board pull-downs: switches stay off
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gate[i] = pins.oe[i] ? pins.level[i] : 1'b0;
      end
   end
endmodule : epwm_switch_model

// ==== epwm_unit.sv ====
// module: enhanced pwm unit with period timer, power and clock-fail handling
// Functional notes
// - deep sleep freezes timer and pins, registers still take writes
// - driven pwm pins hold level while asleep
// - wake resumes from frozen state unchanged
// - primary idle keeps primary clock rate
// - low-power idle uses its tick, sleep none
// - clock fail switches internal, sets flag
// - after failure keep running on internal
// - reset inputs all pins, clears registers but limit, dir
// - reset comes up single-output basic mode
// - reduced variant hides delay, bd-shutdown bits
module epwm_unit #(
   parameter bit REDUCED_PINS = 1'b0
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // register port
   input  wire epwm_pkg::bus_req_s bus,
   output logic [7:0]             rdata,
   // clock ticks from the oscillator block (async)
   input  wire logic              primary_tick,
   input  wire logic              low_power_tick,
   input  wire logic              internal_osc_tick,
   input  wire logic              primary_clock_fail,
   // shutdown sources (async)
   input  wire logic              fault_n,
   input  wire logic [1:0]        comparator,
   // pwm pins
   output epwm_pkg::pwm_pins_s    pins,
   // interrupt
   output logic                   irq
);

   // synchronisers: first stage read only by second stage
   logic [7:0] sync_a;
   logic [7:0] sync_b;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync_a <= 8'h00;
         sync_b <= 8'h00;
      end else begin
         sync_a <= {comparator, ~fault_n, primary_clock_fail,
                    internal_osc_tick, low_power_tick, primary_tick, 1'b0};
         sync_b <= sync_a;
      end
   end

   logic       s_pri_tick;
   logic       s_lp_tick;
   logic       s_int_tick;
   logic       s_fail;
   logic       s_fault;
   logic [1:0] s_cmp;
   assign s_pri_tick = sync_b[1];
   assign s_lp_tick  = sync_b[2];
   assign s_int_tick = sync_b[3];
   assign s_fail     = sync_b[4];
   assign s_fault    = sync_b[5];
   assign s_cmp      = sync_b[7:6];

   // edge memory of the tick inputs
   logic [2:0] tick_prev;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) tick_prev <= 3'h0;
      else       tick_prev <= {s_int_tick, s_lp_tick, s_pri_tick};
   end

   // registers
   logic [7:0] counter;
   logic [7:0] tctrl;
   logic [7:0] limit;
   logic [7:0] duty_lo;
   logic [7:0] duty_hi;
   logic [7:0] uctrl;
   logic [7:0] shut;
   logic [7:0] restart;
   logic [7:0] flags1;
   logic [7:0] flags2;
   logic [7:0] irq_en;
   logic [7:0] pwr;
   logic [7:0] dir;
   logic [1:0] status;
   epwm_pkg::clk_src_e clk_src;

   // write masks of the optional fields
   function automatic logic [7:0] variant_mask(input logic [7:0] full,
                                               input logic [7:0] red);
      variant_mask = REDUCED_PINS ? red : full;
   endfunction : variant_mask

   logic       wr_hit;
   logic [1:0] pmode;
   logic       sleeping;
   assign pmode    = pwr[1:0];
   assign sleeping = (pmode == epwm_pkg::PWR_SLEEP);

   // clock source selection
   // fail forces internal
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         clk_src <= epwm_pkg::src_primary;
      end else if (pwr[epwm_pkg::PWR_FSCM] && s_fail) begin
         clk_src <= epwm_pkg::src_internal;
      end else if (clk_src != epwm_pkg::src_internal) begin
         if (pmode == epwm_pkg::PWR_LP_IDLE) clk_src <= epwm_pkg::src_low_power;
         else                                clk_src <= epwm_pkg::src_primary;
      end
   end

   logic tick;
   always_comb begin
      case (clk_src)
         epwm_pkg::src_primary:   tick = s_pri_tick & ~tick_prev[0];
         epwm_pkg::src_low_power: tick = s_lp_tick & ~tick_prev[1];
         epwm_pkg::src_internal:  tick = s_int_tick & ~tick_prev[2];
         default:                 tick = 1'b0;
      endcase
   end

   logic advance;
   assign advance = tick & ~sleeping & tctrl[epwm_pkg::TCTRL_ON];

   // period timer and duty latch
   logic       period_end;
   logic [9:0] duty_latched;
   logic [9:0] phase;
   logic [1:0] sub;
   assign period_end = advance && (sub == 2'h3) && (counter == limit);
   assign phase      = {counter, sub};
   assign wr_hit     = bus.wr;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         counter <= epwm_pkg::RST_BYTE;
         sub     <= 2'h0;
      end else if (wr_hit && bus.addr == epwm_pkg::OFF_COUNTER) begin
         counter <= bus.wdata;
         sub     <= 2'h0;
      end else if (advance) begin
         sub <= sub + 2'h1;
         if (sub == 2'h3) counter <= (counter == limit) ? 8'h00 : counter + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)           duty_latched <= 10'h000;
      else if (period_end) duty_latched <= {duty_lo, uctrl[5:4]};
   end

   // auto-shutdown condition
   logic shut_cond;
   always_comb begin
      case (shut[6:4])
         3'h1:    shut_cond = s_cmp[0];
         3'h2:    shut_cond = s_cmp[1];
         3'h3:    shut_cond = |s_cmp;
         3'h4:    shut_cond = s_fault;
         3'h5:    shut_cond = s_fault | s_cmp[0];
         3'h6:    shut_cond = s_fault | s_cmp[1];
         3'h7:    shut_cond = s_fault | (|s_cmp);
         default: shut_cond = 1'b0;
      endcase
   end

   // pwm level and shutdown hold for the period
   logic pwm_raw;
   logic shut_active;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_raw     <= 1'b0;
         shut_active <= 1'b0;
      end else if (advance) begin
         pwm_raw <= (phase < duty_latched);
         if (period_end) shut_active <= shut[epwm_pkg::SHUT_ASE];
      end
   end

   // pin drive: single output until a nonzero mode in uctrl[7:6] selected
   // pins frozen while asleep
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pins <= '0;
      end else if (!sleeping) begin
         logic pol_a;
         logic pol_b;
         logic act;
         pol_a = uctrl[1];
         pol_b = uctrl[0];
         act   = (uctrl[3:2] == 2'h3);
         for (int i = 0; i < 4; i++) begin
            logic lvl;
            logic en;
            lvl = pwm_raw ^ ((i % 2 == 0) ? pol_a : pol_b);
            en  = act && !dir[i] && (uctrl[7:6] != 2'h0 || i == 0);
            if (i == 1 && uctrl[7:6] == 2'h2) lvl = ~lvl;
            if (shut_active || shut[epwm_pkg::SHUT_ASE]) begin
               logic [1:0] st;
               st  = (i % 2 == 0) ? shut[3:2] : shut[1:0];
               lvl = st[0];
               en  = en && !st[1];
            end
            pins.level[i] <= lvl;
            pins.oe[i]    <= en;
         end
      end
   end

   // register writes
   // registers clear on reset, except limit and dir which load all ones
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tctrl   <= epwm_pkg::RST_BYTE;
         limit   <= epwm_pkg::RST_LIMIT;
         duty_lo <= epwm_pkg::RST_BYTE;
         duty_hi <= epwm_pkg::RST_BYTE;
         uctrl   <= epwm_pkg::RST_BYTE;
         restart <= epwm_pkg::RST_BYTE;
         irq_en  <= epwm_pkg::RST_BYTE;
         pwr     <= epwm_pkg::RST_BYTE;
         dir     <= epwm_pkg::RST_DIR;
      end else if (wr_hit) begin
         case (bus.addr)
            epwm_pkg::OFF_TCTRL:   tctrl   <= bus.wdata & epwm_pkg::TCTRL_MASK;
            epwm_pkg::OFF_LIMIT:   limit   <= bus.wdata;
            epwm_pkg::OFF_DUTY_LO: duty_lo <= bus.wdata;
            epwm_pkg::OFF_DUTY_HI: duty_hi <= bus.wdata;
            epwm_pkg::OFF_UCTRL:   uctrl   <= bus.wdata;
            epwm_pkg::OFF_RESTART: restart <= bus.wdata &
               variant_mask(8'hFF, epwm_pkg::RESTART_REDUCED_MASK);
            epwm_pkg::OFF_IRQ_EN:  irq_en  <= bus.wdata & epwm_pkg::IRQ_MASK;
            epwm_pkg::OFF_PWR:     pwr     <= bus.wdata;
            epwm_pkg::OFF_DIR:     dir     <= bus.wdata;
            default: ;
         endcase
      end
   end

   // shutdown control: sets on event, clear refused while active
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         shut <= epwm_pkg::RST_BYTE;
      end else begin
         logic [7:0] nv;
         nv = shut;
         if (wr_hit && bus.addr == epwm_pkg::OFF_SHUT) begin
            nv = bus.wdata & variant_mask(8'hFF, epwm_pkg::SHUT_REDUCED_MASK);
            if (shut_cond) nv[epwm_pkg::SHUT_ASE] = 1'b1;
         end
         if (shut_cond) nv[epwm_pkg::SHUT_ASE] = 1'b1;
         else if (restart[epwm_pkg::RESTART_EN] && shut[epwm_pkg::SHUT_ASE]
                  && !(wr_hit && bus.addr == epwm_pkg::OFF_SHUT))
            nv[epwm_pkg::SHUT_ASE] = 1'b0;
         shut <= nv;
      end
   end

   // peripheral flags: hardware set wins over software write
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flags1 <= epwm_pkg::RST_BYTE;
         flags2 <= epwm_pkg::RST_BYTE;
      end else begin
         if (wr_hit && bus.addr == epwm_pkg::OFF_FLAGS1) flags1 <= bus.wdata;
         if (period_end) flags1[epwm_pkg::FLAGS1_PERIOD] <= 1'b1;
         if (wr_hit && bus.addr == epwm_pkg::OFF_FLAGS2)
            flags2 <= bus.wdata & epwm_pkg::FLAGS2_MASK;
         if (pwr[epwm_pkg::PWR_FSCM] && s_fail)
            flags2[epwm_pkg::FLAGS2_OSCF] <= 1'b1;
      end
   end

   // sticky event status, write-one clear, set wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status <= 2'h0;
      end else begin
         logic [1:0] setv;
         logic [1:0] clrv;
         setv = {pwr[epwm_pkg::PWR_FSCM] & s_fail, period_end};
         clrv = (wr_hit && bus.addr == epwm_pkg::OFF_IRQ_CLR) ?
                bus.wdata[1:0] : 2'h0;
         status <= (status & ~clrv) | setv;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) irq <= 1'b0;
      else       irq <= |(status & irq_en[1:0]);
   end

   // read data, one cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            epwm_pkg::OFF_COUNTER: rdata <= counter;
            epwm_pkg::OFF_TCTRL:   rdata <= tctrl;
            epwm_pkg::OFF_LIMIT:   rdata <= limit;
            epwm_pkg::OFF_DUTY_LO: rdata <= duty_lo;
            epwm_pkg::OFF_DUTY_HI: rdata <= duty_hi;
            epwm_pkg::OFF_UCTRL:   rdata <= uctrl;
            epwm_pkg::OFF_SHUT:    rdata <= shut;
            epwm_pkg::OFF_RESTART: rdata <= restart;
            epwm_pkg::OFF_FLAGS1:  rdata <= flags1;
            epwm_pkg::OFF_FLAGS2:  rdata <= flags2;
            epwm_pkg::OFF_IRQ_EN:  rdata <= irq_en;
            epwm_pkg::OFF_IRQ_CLR: rdata <= {6'h00, status};
            // clock source in [3:2] over the mode in [1:0]
            epwm_pkg::OFF_PWR:     rdata <= {4'h0, clk_src, pwr[1:0]};
            epwm_pkg::OFF_DIR:     rdata <= dir;
            default:               rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule : epwm_unit

// ==== epwm_unit_checker.sv ====
// port checker for the enhanced pwm unit, bound below
module epwm_unit_checker #(
   parameter bit REDUCED_PINS = 1'b0
) (
   // clock and reset
   input wire logic                sys_clk,
   input wire logic                nrst,
   // register port
   input wire epwm_pkg::bus_req_s  bus,
   input wire logic [7:0]          rdata,
   // ticks and clock fail
   input wire logic                primary_tick,
   input wire logic                low_power_tick,
   input wire logic                internal_osc_tick,
   input wire logic                primary_clock_fail,
   // shutdown sources
   input wire logic                fault_n,
   input wire logic [1:0]          comparator,
   // pins and interrupt
   input wire epwm_pkg::pwm_pins_s pins,
   input wire logic                irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pwr_q;
   logic [1:0] en_q;
   logic [3:0] dir_q;
   logic [2:0] sleep_cnt;
   logic [3:0] quiet_cnt;
   logic [6:0] in_q;
   logic [6:0] in_now;
   logic       act;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // any input change that may move the pins
   assign in_now = {primary_tick, low_power_tick, internal_osc_tick,
                    primary_clock_fail, fault_n, comparator};
   assign act    = bus.wr || (in_now != in_q);
   // shadow copies of the registers the checks lean on
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= 8'h00;
         en_q  <= 2'h0;
         dir_q <= 4'hF;
      end else if (bus.wr) begin
         case (bus.addr)
            epwm_pkg::OFF_PWR:    pwr_q <= bus.wdata;
            epwm_pkg::OFF_IRQ_EN: en_q <= bus.wdata[1:0];
            epwm_pkg::OFF_DIR:    dir_q <= bus.wdata[3:0];
            default: ;
         endcase
      end
   end
   // cycles asleep and cycles without activity
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sleep_cnt <= 3'h0;
         quiet_cnt <= 4'h0;
         in_q      <= 7'h00;
      end else begin
         in_q <= in_now;
         if (bus.wr || pwr_q[1:0] != epwm_pkg::PWR_SLEEP) sleep_cnt <= 3'h0;
         else if (sleep_cnt != 3'h7) sleep_cnt <= sleep_cnt + 3'h1;
         if (act) quiet_cnt <= 4'h0;
         else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
      end
   end
   AST_RDATA_IDLE: assert property ( // read timing
      !$past(bus.rd) || $past(bus.addr) > epwm_pkg::OFF_DIR |-> rdata == 8'h00)
      else $error("read data not zero outside a mapped read");
   AST_RESET_STATE: assert property (disable iff (1'b0)
      !nrst |-> pins.oe == 4'h0 && !irq && rdata == 8'h00)
      else $error("outputs not cleared during reset");
   AST_SLEEP_FROZEN: assert property (
      sleep_cnt >= 3'h4 |-> $stable(pins))
      else $error("pins moved while asleep");
   AST_QUIET_HOLD: assert property (
      quiet_cnt >= 4'h6 |-> $stable(pins))
      else $error("pins moved without a tick or write");
   AST_DIR_INPUT: assert property (
      (pins.oe & dir_q & $past(dir_q)) == 4'h0)
      else $error("pin driven while set as input");
   AST_IRQ_MASKED: assert property ( // irq masking
      irq |-> (en_q | $past(en_q)) != 2'h0)
      else $error("interrupt high with no source enabled");
   AST_OSC_FAIL_IRQ: assert property (
      $rose(primary_clock_fail) && pwr_q[epwm_pkg::PWR_FSCM]
      && en_q[epwm_pkg::EV_OSCF] |-> ##[1:8] irq)
      else $error("clock failure raised no interrupt");
   AST_REDUCED_ZERO: assert property (
      bus.rd && REDUCED_PINS && bus.addr == epwm_pkg::OFF_RESTART
      |=> rdata[6:0] == 7'h00)
      else $error("delay count bits visible on reduced variant");
endmodule : epwm_unit_checker

bind epwm_unit epwm_unit_checker #(.REDUCED_PINS(REDUCED_PINS)) i_chk (
   .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
   .primary_tick(primary_tick), .low_power_tick(low_power_tick),
   .internal_osc_tick(internal_osc_tick),
   .primary_clock_fail(primary_clock_fail), .fault_n(fault_n),
   .comparator(comparator), .pins(pins), .irq(irq));

// ==== epwm_unit_tb_top.sv ====
// self-checking testbench for the enhanced pwm unit
module epwm_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                sys_clk;
   logic                nrst;
   epwm_pkg::bus_req_s  bus;
   logic [7:0]          rdata;
   logic [2:0]          tk;
   logic                fail;
   epwm_pkg::pwm_pins_s pins;
   logic                irq;
   logic [3:0]          gate;
   logic [7:0]          v;
   logic [7:0]          c0;
   logic [7:0]          p0;
   int                  err_count;
   int                  comparisons;
   int                  hi;
   int                  cycles;
   epwm_unit #(.REDUCED_PINS(1'b1)) i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .primary_tick(tk[0]), .low_power_tick(tk[1]),
      .internal_osc_tick(tk[2]), .primary_clock_fail(fail),
      .fault_n(1'b1), .comparator(2'h0), .pins(pins), .irq(irq));
   epwm_switch_model i_sw (.pins(pins), .gate(gate));
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus <= '0;
   endtask : wr
   // read data stands in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus <= '0;
      #1 v = rdata;
   endtask : rd
   // one tick edge every four clocks, pin a sampled per tick
   task automatic tick(input int s, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         tk[s] <= 1'b1;
         repeat (2) @(posedge sys_clk);
         tk[s] <= 1'b0;
         @(posedge sys_clk);
         #1 hi += int'(gate[0]);
      end
   endtask : tick
   // counter moves by f (limit 1 wraps) after n ticks of source s
   task automatic step(input int s, input int n, input logic [7:0] f);
      rd(epwm_pkg::OFF_COUNTER);
      c0 = v;
      tick(s, n);
      rd(epwm_pkg::OFF_COUNTER);
      check(v, c0 ^ f);
   endtask : step
   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   // cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      nrst = 1'b0;
      bus  = '0;
      tk   = 3'h0;
      fail = 1'b0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      // whole map after reset, one unmapped place at the end
      for (int a = 0; a <= 'h38; a += 4) begin
         rd(8'(a));
         check(v, (a == 'h08 || a == 'h34) ? 8'hFF : 8'h00);
      end
      check({4'h0, pins.oe}, 8'h00);
      $display("test reset_values done");
      // half duty on pin a, single output after reset
      wr(epwm_pkg::OFF_LIMIT, 8'h01);
      wr(epwm_pkg::OFF_DUTY_LO, 8'h01);
      wr(epwm_pkg::OFF_UCTRL, 8'h0C);
      wr(epwm_pkg::OFF_TCTRL, 8'h04);
      wr(epwm_pkg::OFF_DIR, 8'h00);
      tick(0, 16);
      hi = 0;
      tick(0, 16);
      check(8'(hi), 8'h08);
      check({4'h0, pins.oe}, 8'h01);
      rd(epwm_pkg::OFF_FLAGS1);
      check(v & 8'h02, 8'h02);
      $display("test basic_pwm done");
      // each power mode and its clock source
      wr(epwm_pkg::OFF_PWR, {6'h0, epwm_pkg::PWR_LP_IDLE});
      step(0, 8, 8'h00);
      step(1, 4, 8'h01);
      rd(epwm_pkg::OFF_PWR);
      check({6'h0, v[3:2]}, 8'h01);
      wr(epwm_pkg::OFF_PWR, {6'h0, epwm_pkg::PWR_PRIMARY_CLOCK_IDLE_MODE});
      step(0, 4, 8'h01);
      wr(epwm_pkg::OFF_PWR, {6'h0, epwm_pkg::PWR_SLEEP});
      step(0, 8, 8'h00);
      p0 = pins;
      // polarity change must not reach frozen pins
      wr(epwm_pkg::OFF_UCTRL, 8'h0E);
      step(1, 8, 8'h00);
      check(pins, p0);
      check({4'h0, pins.oe}, 8'h01);
      wr(epwm_pkg::OFF_PWR, {6'h0, epwm_pkg::PWR_RUN});
      step(0, 4, 8'h01);
      $display("test power_modes done");
      // interrupt raise and mask, then clock failure
      wr(epwm_pkg::OFF_IRQ_CLR, 8'h03);
      wr(epwm_pkg::OFF_IRQ_EN, 8'h01);
      tick(0, 8);
      check({7'h0, irq}, 8'h01);
      wr(epwm_pkg::OFF_IRQ_EN, 8'h02);
      repeat (2) @(posedge sys_clk);
      #1 check({7'h0, irq}, 8'h00);
      wr(epwm_pkg::OFF_PWR, 8'h04);
      fail <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 check({7'h0, irq}, 8'h01);
      rd(epwm_pkg::OFF_FLAGS2);
      check(v, 8'h80);
      rd(epwm_pkg::OFF_PWR);
      check({6'h0, v[3:2]}, 8'h02);
      fail <= 1'b0;
      step(0, 8, 8'h00);
      step(2, 4, 8'h01);
      wr(epwm_pkg::OFF_IRQ_CLR, 8'h02);
      rd(epwm_pkg::OFF_IRQ_CLR);
      check(v & 8'h02, 8'h00);
      check({7'h0, irq}, 8'h00);
      $display("test clock_fail done");
      // reduced-pin variant hides delay and b/d shutdown bits
      wr(epwm_pkg::OFF_RESTART, 8'hFF);
      rd(epwm_pkg::OFF_RESTART);
      check(v, 8'h80);
      wr(epwm_pkg::OFF_SHUT, 8'h0F);
      rd(epwm_pkg::OFF_SHUT);
      check(v, 8'h0C);
      $display("test reduced_bits done");
      // second reset in mid-run
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 check({3'h0, irq, pins.oe}, 8'h00);
      @(posedge sys_clk);
      nrst <= 1'b1;
      rd(epwm_pkg::OFF_UCTRL);
      check(v, 8'h00);
      rd(epwm_pkg::OFF_PWR);
      check(v, 8'h00);
      rd(epwm_pkg::OFF_DIR);
      check(v, 8'hFF);
      $display("test mid_reset done");
      give_verdict();
   end
endmodule : epwm_unit_tb_top
